// >>> src/ssp_map.vh
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
// Frame layout
`define SSP_INSTR_BITS 6'd8
`define SSP_ARG2_BITS 7'd16
`define SSP_ARG4_BITS 7'd32
`define SSP_ARG8_BITS 7'd64
// Instruction codes
`define SSP_CMD_READ_ACC 8'h50
`define SSP_CMD_READ_TEMP 8'h54
`define SSP_CMD_ADV_4 8'h58
`define SSP_CMD_ADV_8 8'h78
`define SSP_CMD_ADV_2 8'h7C
// Power states and calibration length
`define SSP_ST_OFF 2'h0
`define SSP_ST_CALIB 2'h1
`define SSP_ST_RUN 2'h2
`define SSP_CALIB_CYCLES 8'h10
`endif

// >>> src/ssp_sync.v
`timescale 1ns/1ps
module ssp_sync #(
   parameter W = 4
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Asynchronous in, synchronous out
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] stage1;
   // First stage feeds only the second
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // ssp_sync

// >>> src/ssp_slave.v
// What this block does
// - Serial slave only, clock mode zero: clock idles low, capture on rise.
// - Serial output floats whenever slave select is high.
// - Pulse sample-ready output each time a new sample arrives in the run state.
// - Active-low reset input reloads calibration into working configuration.
// - Self-test output high while running and healthy, low on detected failure or when not running.
// - Block runs only while enable is high.
// - Enable low puts the block into power-down, halting operation.
// - Frame is one instruction byte then two, four or eight argument bytes.
`timescale 1ns/1ps
`include "ssp_map.vh"
module ssp_slave #(
   parameter DATA_W = 24,
   parameter TEMP_W = 14,
   parameter CALIB_W = 32,
   parameter CALIB_DEFAULT = 32'h0000_0000
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Serial pins
   input wire sclk,
   input wire mosi,
   input wire ssel_n,
   output reg miso,
   output reg miso_oe,
   // Side-band pins
   input wire enable,
   input wire calib_reload_reset_n,
   output reg sample_ready_pulse,
   output reg selftest_ok_out,
   // Sensor core side
   input wire sample_valid,
   input wire [DATA_W-1:0] sample_data,
   input wire [TEMP_W-1:0] temp_data,
   input wire selftest_fail,
   input wire [CALIB_W-1:0] calib_store,
   // Frame results
   output reg [CALIB_W-1:0] calib_work,
   output reg [7:0] frame_instr,
   output reg [63:0] frame_arg,
   output reg frame_done,
   output reg frame_error
);
   wire [3:0] synced;
   ssp_sync #(.W(4)) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({sclk, mosi, ssel_n, calib_reload_reset_n}),
      .sync_out(synced)
   );
   wire sclk_s = synced[3];
   wire mosi_s = synced[2];
   wire ssel_n_s = synced[1];
   wire reload_n_s = synced[0];
   reg sclk_d;
   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   reg [1:0] state;
   reg [7:0] calib_cnt;
   wire running = (state == `SSP_ST_RUN);
   // Power state: reload then run, drop to off on enable low
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= `SSP_ST_OFF;
         calib_cnt <= 8'h00;
         calib_work <= CALIB_DEFAULT;
      end else begin
         case (state)
            `SSP_ST_OFF: begin
               if (enable) begin
                  state <= `SSP_ST_CALIB;
                  calib_cnt <= 8'h00;
               end
            end
            `SSP_ST_CALIB: begin
               calib_work <= calib_store;
               calib_cnt <= calib_cnt + 8'h01;
               if (!enable)
                  state <= `SSP_ST_OFF;
               else if (calib_cnt == `SSP_CALIB_CYCLES - 8'h01)
                  state <= `SSP_ST_RUN;
            end
            `SSP_ST_RUN: begin
               if (!enable)
                  state <= `SSP_ST_OFF;
               else if (!reload_n_s) begin
                  state <= `SSP_ST_CALIB;
                  calib_cnt <= 8'h00;
               end
            end
            default: state <= `SSP_ST_OFF;
         endcase
      end
   end
   // Shift engine; the argument length follows the instruction
   reg [6:0] bit_cnt;
   reg [6:0] arg_len;
   reg [7:0] instr_sh;
   reg [63:0] arg_sh;
   reg [63:0] tx_sh;
   reg ready_flag;
   reg [DATA_W-1:0] held_sample;
   reg st_ok;
   function [6:0] len_of;
      input [7:0] ins;
      begin
         case (ins)
            `SSP_CMD_READ_ACC: len_of = `SSP_ARG4_BITS;
            `SSP_CMD_ADV_4: len_of = `SSP_ARG4_BITS;
            `SSP_CMD_ADV_8: len_of = `SSP_ARG8_BITS;
            `SSP_CMD_READ_TEMP: len_of = `SSP_ARG2_BITS;
            `SSP_CMD_ADV_2: len_of = `SSP_ARG2_BITS;
            default: len_of = 7'd0;
         endcase
      end
   endfunction
   wire [7:0] next_instr = {instr_sh[6:0], mosi_s};
   wire [6:0] instr_end = {1'b0, `SSP_INSTR_BITS};
   wire [6:0] total = instr_end + arg_len;
   // Reply words: acceleration with ready and self-test bits, MSB first
   wire [31:0] acc_word = {held_sample, 6'h00, ready_flag, st_ok};
   wire [15:0] temp_word = {2'h0, temp_data};
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d <= 1'b0;
         bit_cnt <= 7'h00;
         arg_len <= 7'h00;
         instr_sh <= 8'h00;
         arg_sh <= 64'h0;
         tx_sh <= 64'h0;
         miso <= 1'b0;
         miso_oe <= 1'b0;
         frame_instr <= 8'h00;
         frame_arg <= 64'h0;
         frame_done <= 1'b0;
         frame_error <= 1'b0;
         ready_flag <= 1'b0;
         held_sample <= {DATA_W{1'b0}};
         st_ok <= 1'b0;
         sample_ready_pulse <= 1'b0;
         selftest_ok_out <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         frame_done <= 1'b0;
         frame_error <= 1'b0;
         sample_ready_pulse <= 1'b0;
         // Output driven only while selected and powered
         miso_oe <= ~ssel_n_s & running;
         st_ok <= running & ~selftest_fail;
         selftest_ok_out <= running & ~selftest_fail;
         if (running && sample_valid) begin
            held_sample <= sample_data;
            sample_ready_pulse <= 1'b1;
         end
         if (ssel_n_s || !running) begin
            // Deselect mid-frame aborts; short frames flag an error
            if (bit_cnt != 7'h00)
               frame_error <= 1'b1;
            bit_cnt <= 7'h00;
            arg_len <= 7'h00;
            miso <= 1'b0;
         end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt < instr_end) begin
               instr_sh <= next_instr;
               if (bit_cnt == instr_end - 7'h01) begin
                  arg_len <= len_of(next_instr);
                  arg_sh <= 64'h0;
                  if (next_instr == `SSP_CMD_READ_ACC) begin
                     tx_sh <= {acc_word, 32'h0};
                     ready_flag <= 1'b0;
                  end else if (next_instr == `SSP_CMD_READ_TEMP)
                     tx_sh <= {temp_word, 48'h0};
                  else
                     tx_sh <= 64'h0;
                  if (len_of(next_instr) == 7'd0) begin
                     frame_error <= 1'b1;
                     bit_cnt <= 7'h00;
                  end
               end
            end else begin
               arg_sh <= {arg_sh[62:0], mosi_s};
               if (bit_cnt == total - 7'h01) begin
                  frame_instr <= instr_sh;
                  frame_arg <= {arg_sh[62:0], mosi_s};
                  frame_done <= 1'b1;
                  bit_cnt <= 7'h00;
               end
            end
         end else if (sclk_fall && bit_cnt >= instr_end) begin
            // Drive the next reply bit after the falling edge
            miso <= tx_sh[63];
            tx_sh <= {tx_sh[62:0], 1'b0};
         end
         // New sample wins over a clear in the same cycle
         if (running && sample_valid)
            ready_flag <= 1'b1;
      end
   end
endmodule // ssp_slave

// >>> tb/ssp_slave_monitor.sv
`timescale 1ns/1ps
module ssp_slave_monitor (
   // Clock and reset
   input wire mclk, input wire rst_n,
   // Pins and core inputs watched
   input wire sclk, input wire ssel_n, input wire enable,
   input wire calib_reload_reset_n, input wire selftest_fail,
   input wire [31:0] calib_store, input wire [31:0] calib_work,
   input wire miso, input wire miso_oe, input wire sample_ready_pulse,
   input wire selftest_ok_out, input wire frame_done, input wire frame_error
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   float_idle_a: assert property (ssel_n [*4] |-> !miso_oe)
      else $error("miso driven while deselected");
   miso_edge_a: assert property (miso_oe && $past(miso_oe)
      && $changed(miso) |-> !sclk) else $error("miso moved with clock high");
   rdy_pulse_a: assert property (sample_ready_pulse |=>
      !sample_ready_pulse) else $error("ready pulse too long");
   rdy_off_a: assert property (!enable [*4] |-> !sample_ready_pulse)
      else $error("ready pulse in power-down");
   st_fail_a: assert property (selftest_fail [*2] |->
      !selftest_ok_out) else $error("self-test ok despite failure");
   st_off_a: assert property (!enable [*4] |-> !selftest_ok_out)
      else $error("self-test ok while disabled");
   // Reload pin is synchronised, so allow a few cycles before loading
   calib_load_a: assert property ((enable && !calib_reload_reset_n) [*6]
      |-> calib_work == $past(calib_store)) else $error("calib not reloaded");
   done_excl_a: assert property (!(frame_done && frame_error))
      else $error("done and error together");
   done_pulse_a: assert property (frame_done |=> !frame_done)
      else $error("done pulse too long");
   cover property (frame_done);
   cover property (frame_error);
   cover property (sample_ready_pulse);
endmodule // ssp_slave_monitor
bind ssp_slave ssp_slave_monitor mon (.*);

// >>> tb/ssp_master.sv
`timescale 1ns/1ps
module ssp_master (
   // Serial pins toward the slave
   output reg sclk, output reg mosi, output reg ssel_n,
   input wire miso, input wire miso_oe
);
   reg [71:0] rx;
   initial begin
      sclk = 0;
      mosi = 0;
      ssel_n = 1;
      rx = 0;
   end
   // Clock stands low outside frames
   task xfer(input [71:0] d, input integer bits);
      integer i;
      begin
         ssel_n = 0;
         #64;
         for (i = 0; i < bits; i = i + 1) begin
            mosi = d[71-i];
            #32 sclk = 1;
            rx = {rx[70:0], miso_oe ? miso : ~rx[0]};
            #32 sclk = 0;
         end
         #64 ssel_n = 1;
         mosi = ~mosi; // Released line must not look stable
      end
   endtask
endmodule // ssp_master

// >>> tb/ssp_slave_tb.sv
`timescale 1ns/1ps
`include "ssp_map.vh"
module ssp_slave_tb;
   reg mclk = 0, rst_n = 0, enable = 1, calib_reload_reset_n = 1;
   reg sample_valid = 0, selftest_fail = 0, got_done, got_err, got_rdy;
   reg [23:0] sample_data = 24'hA51C3E;
   reg [13:0] temp_data = 14'h2B4D;
   reg [31:0] calib_store = 32'h1234ABCD;
   reg [7:0] cmd [0:4];
   integer nb [0:4];
   reg [63:0] arg;
   integer num_errors = 0, n_tests = 0, cyc = 0, i;
   wire sclk, mosi, ssel_n, miso, miso_oe, sample_ready_pulse;
   wire selftest_ok_out, frame_done, frame_error;
   wire [31:0] calib_work;
   wire [7:0] frame_instr;
   wire [63:0] frame_arg;
   ssp_slave dut (.*);
   ssp_master m (.*);
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (frame_done) got_done <= 1;
      if (frame_error) got_err <= 1;
      if (sample_ready_pulse) got_rdy <= 1;
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         stop_test;
      end
   end
   task chk(input ok);
      begin
         n_tests = n_tests + 1;
         if (ok !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: output mismatch", $time);
         end
      end
   endtask
   task stop_test;
      begin
         $display("errors %0d of %0d checks", num_errors, n_tests);
         if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task frame(input [7:0] c, input [63:0] a, input integer n, input integer b);
      begin
         got_done = 0;
         got_err = 0;
         m.xfer({c, a << (64 - 8 * n)}, b);
         repeat (12) @(negedge mclk);
      end
   endtask
   task pulse;
      begin
         got_rdy = 0;
         sample_valid = 1;
         @(negedge mclk) sample_valid = 0;
         repeat (4) @(negedge mclk);
      end
   endtask
   initial begin
      cmd[0] = `SSP_CMD_READ_ACC; nb[0] = 4;
      cmd[1] = `SSP_CMD_READ_TEMP; nb[1] = 2;
      cmd[2] = `SSP_CMD_ADV_4; nb[2] = 4;
      cmd[3] = `SSP_CMD_ADV_8; nb[3] = 8;
      cmd[4] = `SSP_CMD_ADV_2; nb[4] = 2;
      repeat (8) @(negedge mclk);
      chk(miso_oe === 0 && selftest_ok_out === 0 && frame_done === 0);
      rst_n = 1;
      repeat (40) @(negedge mclk);
      chk(calib_work === calib_store);
      // Latch a sample first so the acceleration reply has known content
      pulse;
      chk(got_rdy === 1);
      for (i = 0; i < 5; i = i + 1) begin
         arg = 64'hC3A55A3C9617E81D >> (64 - 8 * nb[i]);
         frame(cmd[i], arg, nb[i], 8 + 8 * nb[i]);
         chk(got_done && frame_instr === cmd[i] && frame_arg === arg);
         if (i == 0) chk(m.rx[31:8] === sample_data && m.rx[0]);
         if (i == 0) chk(m.rx[7:1] === 7'h01);
         if (i == 1) chk(m.rx[15:0] === {2'h0, temp_data});
         chk(miso_oe === 0);
      end
      frame(8'hFF, 64'h0, 0, 8);
      chk(got_err === 1);
      frame(`SSP_CMD_READ_TEMP, 64'h0, 2, 12);
      chk(got_err === 1 && got_done === 0);
      pulse;
      chk(got_rdy === 1);
      selftest_fail = 1;
      repeat (4) @(negedge mclk);
      chk(selftest_ok_out === 0);
      selftest_fail = 0;
      calib_store = 32'h5EEDC0DE;
      calib_reload_reset_n = 0;
      // Long enough for the monitor's reload check to see its antecedent
      repeat (8) @(negedge mclk);
      calib_reload_reset_n = 1;
      repeat (30) @(negedge mclk);
      chk(calib_work === 32'h5EEDC0DE && selftest_ok_out === 1);
      enable = 0;
      repeat (6) @(negedge mclk);
      pulse;
      chk(got_rdy === 0 && selftest_ok_out === 0);
      frame(`SSP_CMD_READ_TEMP, 64'h1, 2, 24);
      chk(got_done === 0);
      stop_test;
   end
endmodule // ssp_slave_tb
